// File: rtl/ebu_top.v
// External static memory bus unit with four configurable zones.
`timescale 1ns/1ps
`include "ebu_defines.vh"

module ebu_top #(
	parameter ADDR_W = 20
) (
	input wire CLK,
	input wire SYS_RST,
	input wire CE,
	input wire [3:0] REG_ADDR,
	input wire [15:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [15:0] REG_RDATA,
	input wire CORE_REQ,
	input wire CORE_WRITE,
	input wire CORE_WORD,
	input wire [ADDR_W-1:0] CORE_ADDR,
	input wire [15:0] CORE_WDATA,
	output wire CORE_BUSY,
	output reg CORE_DONE,
	output reg [15:0] CORE_RDATA,
	output wire [ADDR_W-1:0] EXT_ADDR,
	input wire [15:0] EXT_DATA_IN,
	output reg [15:0] EXT_DATA_OUT,
	output wire [1:0] EXT_DATA_OE,
	output wire [3:0] ZONE_SELECT_N,
	output wire BASE_MEMORY_SELECT_N,
	output wire READ_STROBE_N,
	output wire EVEN_BYTE_WRITE_STROBE_N,
	output wire ODD_BYTE_WRITE_STROBE_N
);

// ==========================================================
// Configuration registers
reg [15:0] zcfg [0:3];
reg [15:0] bcfg;
integer i;

// ==========================================================
// Transfer state
// An item is one basic cycle; a split word runs two items on one zone.
reg [3:0] state;
reg [2:0] cnt;
reg item;
reg [1:0] zone;
reg [1:0] last_zone;
reg back_to_back;
reg wr;
reg word;
reg [ADDR_W-1:0] addr;
reg [15:0] wdata;

wire [15:0] cur = zcfg[zone];
wire [2:0] c_wait = cur[`EBU_WAIT_MSB:`EBU_WAIT_LSB];
wire [1:0] c_hold = cur[`EBU_HOLD_MSB:`EBU_HOLD_LSB];
wire c_burst = cur[`EBU_BURST_BIT];
wire c_wide = cur[`EBU_WIDE_BIT];
wire c_fast = cur[`EBU_FAST_BIT];
wire [1:0] c_bw_raw = cur[`EBU_BWAIT_MSB:`EBU_BWAIT_LSB];
// A field value of three is clamped; burst items never stretch past two.
wire [1:0] c_bw = (c_bw_raw > `EBU_BWAIT_MAX) ?
	`EBU_BWAIT_MAX : c_bw_raw;
wire early = bcfg[`EBU_EARLY_BIT];
wire gap_en = bcfg[`EBU_GAP_BIT];

// The zone comes from the top two address bits of the request.
wire [1:0] req_zone = CORE_ADDR[ADDR_W-1:ADDR_W-2];

wire a0 = addr[0];
wire full = word & c_wide & ~a0;
wire two = word & ~full;
wire lane_hi = item ? ~a0 : a0;
wire do_burst = ~wr & two & ~c_wide & c_burst;

// ==========================================================
// Register port
// Unmapped indices read as zero, so software can probe the map safely.
always @(posedge CLK) begin
	if (SYS_RST) begin
		for (i = 0; i < 4; i = i + 1) begin
			zcfg[i] <= `EBU_ZCFG_RESET;
		end
		bcfg <= `EBU_BCFG_RESET;
		REG_RDATA <= 16'h0000;
	end else if (CE) begin
		if (REG_WR) begin
			if (REG_ADDR <= `EBU_REG_ZCFG3) begin
				zcfg[REG_ADDR[1:0]] <= REG_WDATA & `EBU_ZCFG_MASK;
			end else if (REG_ADDR == `EBU_REG_BCFG) begin
				bcfg <= {14'h0, REG_WDATA[1:0]};
			end
		end
		if (REG_RD) begin
			if (REG_ADDR <= `EBU_REG_ZCFG3) begin
				REG_RDATA <= zcfg[REG_ADDR[1:0]];
			end else if (REG_ADDR == `EBU_REG_BCFG) begin
				REG_RDATA <= bcfg;
			end else if (REG_ADDR == `EBU_REG_STAT) begin
				// Status is for debug only and never alters a transfer.
				REG_RDATA <= {8'h00, item, zone, state, CORE_BUSY};
			end else begin
				REG_RDATA <= 16'h0000;
			end
		end else begin
			REG_RDATA <= 16'h0000;
		end
	end
end

// ==========================================================
// Read data capture
// Only the active lane is sampled, so a floating half is harmless.
task capture;
	begin
		if (full) begin
			CORE_RDATA <= EXT_DATA_IN;
		end else if (c_wide) begin
			if (lane_hi) begin
				CORE_RDATA[15:8] <= EXT_DATA_IN[15:8];
			end else begin
				CORE_RDATA[7:0] <= EXT_DATA_IN[7:0];
			end
		end else if (lane_hi) begin
			CORE_RDATA[15:8] <= EXT_DATA_IN[7:0];
		end else begin
			CORE_RDATA[7:0] <= EXT_DATA_IN[7:0];
		end
	end
endtask

// Start of one item, fast reads skip straight to the one-clock form.
task start_item;
	begin
		if (~wr & c_fast) begin
			state <= `EBU_S_T12;
		end else begin
			state <= `EBU_S_T1;
		end
	end
endtask

// After hold: a split word runs its second basic cycle, else done.
task finish_item;
	begin
		if (two & ~item) begin
			item <= 1'b1;
			start_item;
		end else begin
			CORE_DONE <= 1'b1;
			back_to_back <= 1'b1;
			last_zone <= zone;
			state <= `EBU_S_IDLE;
		end
	end
endtask

// Hold clocks keep address and write data valid for slow parts.
task end_item;
	begin
		if (c_hold != 2'h0) begin
			cnt <= {1'b0, c_hold} - 3'h1;
			state <= `EBU_S_HOLD;
		end else begin
			finish_item;
		end
	end
endtask

// ==========================================================
// Sequencer
// A normal item walks T1, optional waits, T2, T3 on an early write and optional hold clocks; a fast read uses T12.
// A split word repeats that walk for its second byte on the same zone; a burst read goes to TB/T2B instead.
always @(posedge CLK) begin
	if (SYS_RST) begin
		state <= `EBU_S_IDLE;
		cnt <= 3'h0;
		item <= 1'b0;
		zone <= 2'h0;
		last_zone <= 2'h0;
		back_to_back <= 1'b0;
		wr <= 1'b0;
		word <= 1'b0;
		addr <= {ADDR_W{1'b0}};
		wdata <= 16'h0000;
		CORE_DONE <= 1'b0;
		CORE_RDATA <= 16'h0000;
	end else if (CE) begin
		CORE_DONE <= 1'b0;
		case (state)
		`EBU_S_IDLE: begin
			if (CORE_REQ) begin
				addr <= CORE_ADDR;
				zone <= req_zone;
				wr <= CORE_WRITE;
				word <= CORE_WORD;
				wdata <= CORE_WDATA;
				item <= 1'b0;
				// Only a request in the clock right after a transfer needs the gap.
				if (gap_en & back_to_back & (req_zone != last_zone)) begin
					state <= `EBU_S_GAP;
				end else if (~CORE_WRITE &
					zcfg[req_zone][`EBU_FAST_BIT]) begin
					state <= `EBU_S_T12;
				end else begin
					state <= `EBU_S_T1;
				end
			end else begin
				back_to_back <= 1'b0;
			end
		end
		`EBU_S_GAP: begin
			back_to_back <= 1'b0;
			start_item;
		end
		`EBU_S_T1: begin
			if (c_wait != 3'h0) begin
				cnt <= c_wait - 3'h1;
				state <= `EBU_S_TW;
			end else begin
				state <= `EBU_S_T2;
			end
		end
		`EBU_S_TW: begin
			if (cnt == 3'h0) begin
				state <= `EBU_S_T2;
			end else begin
				cnt <= cnt - 3'h1;
			end
		end
		`EBU_S_T2: begin
			if (~wr) begin
				capture;
				if (do_burst & ~item) begin
					item <= 1'b1;
					if (c_bw != 2'h0) begin
						cnt <= {1'b0, c_bw} - 3'h1;
						state <= `EBU_S_TB;
					end else begin
						state <= `EBU_S_T2B;
					end
				end else begin
					end_item;
				end
			end else if (early) begin
				state <= `EBU_S_T3;
			end else begin
				end_item;
			end
		end
		`EBU_S_TB: begin
			if (cnt == 3'h0) begin
				state <= `EBU_S_T2B;
			end else begin
				cnt <= cnt - 3'h1;
			end
		end
		`EBU_S_T2B: begin
			capture;
			end_item;
		end
		`EBU_S_T3: begin
			end_item;
		end
		`EBU_S_T12: begin
			capture;
			end_item;
		end
		`EBU_S_HOLD: begin
			if (cnt == 3'h0) begin
				finish_item;
			end else begin
				cnt <= cnt - 3'h1;
			end
		end
		default: begin
			state <= `EBU_S_IDLE;
		end
		endcase
	end
end

// ==========================================================
// Pin decode
// The data pins are taken as synchronous to the clock, so no synchroniser
// sits in the read path; a slower part must be given wait clocks instead.
wire s_t1 = (state == `EBU_S_T1);
wire s_tw = (state == `EBU_S_TW);
wire s_t2 = (state == `EBU_S_T2);
wire s_t3 = (state == `EBU_S_T3);
wire s_hold = (state == `EBU_S_HOLD);
wire s_burst = (state == `EBU_S_TB) | (state == `EBU_S_T2B);
wire s_fast = (state == `EBU_S_T12);
wire busy_cycle = s_t1 | s_tw | s_t2 | s_t3 | s_hold | s_burst | s_fast;

wire rd_on = ~wr & (s_t1 | s_tw | s_t2 | s_burst | s_fast);
// Early write raises the write strobe first and selects a clock later.
wire wr_on = wr & (s_tw | s_t2 | (early & s_t1));
wire sel_on = rd_on | (wr & (s_tw | s_t2 | (~early & s_t1)));
wire drive = wr & (s_tw | s_t2 | s_t3 | s_hold);

assign CORE_BUSY = (state != `EBU_S_IDLE);
assign READ_STROBE_N = ~rd_on;

genvar z;
generate
	for (z = 0; z < 4; z = z + 1) begin : g_sel
		assign ZONE_SELECT_N[z] = ~(sel_on & (zone == z));
	end
endgenerate

// Zones 1 and 2 carry the fast and slow halves of base memory.
assign BASE_MEMORY_SELECT_N = ZONE_SELECT_N[1] &
	ZONE_SELECT_N[2];

// Address stays valid from the first cycle to the last hold.
assign EXT_ADDR = busy_cycle ?
	{addr[ADDR_W-1:1], full ? 1'b0 : lane_hi} :
	{ADDR_W{1'b0}};

assign EVEN_BYTE_WRITE_STROBE_N = ~(wr_on &
	(full | ~c_wide | ~lane_hi));
assign ODD_BYTE_WRITE_STROBE_N = ~(wr_on & c_wide &
	(full | lane_hi));

// The unused half is released so another driver may own it.
assign EXT_DATA_OE[0] = drive & (full | ~c_wide | ~lane_hi);
assign EXT_DATA_OE[1] = drive & c_wide & (full | lane_hi);

always @(posedge CLK) begin
	if (SYS_RST) begin
		EXT_DATA_OUT <= 16'h0000;
	end else if (CE) begin
		if (state == `EBU_S_T1 || state == `EBU_S_HOLD) begin
			if (full) begin
				EXT_DATA_OUT <= wdata;
			end else if (c_wide) begin
				EXT_DATA_OUT <= wdata;
			end else if (lane_hi) begin
				EXT_DATA_OUT <= {8'h00, wdata[15:8]};
			end else begin
				EXT_DATA_OUT <= {8'h00, wdata[7:0]};
			end
		end
	end
end

endmodule // ebu_top

// File: rtl/ebu_defines.vh
// Register map, field layout, reset values and states of the bus unit.
`ifndef EBU_DEFINES_VH
`define EBU_DEFINES_VH
// ==========================================================
// Register indices
`define EBU_REG_ZCFG0 4'h0
`define EBU_REG_ZCFG1 4'h1
`define EBU_REG_ZCFG2 4'h2
`define EBU_REG_ZCFG3 4'h3
`define EBU_REG_BCFG 4'h4
`define EBU_REG_STAT 4'h5
// ==========================================================
// Zone configuration fields
`define EBU_WAIT_LSB 0
`define EBU_WAIT_MSB 2
`define EBU_HOLD_LSB 3
`define EBU_HOLD_MSB 4
`define EBU_BURST_BIT 5
`define EBU_WIDE_BIT 6
`define EBU_FAST_BIT 7
`define EBU_BWAIT_LSB 8
`define EBU_BWAIT_MSB 9
`define EBU_ZCFG_MASK 16'h03ff
`define EBU_ZCFG_RESET 16'h0007
`define EBU_BWAIT_MAX 2'h2
// ==========================================================
// Bus configuration fields
`define EBU_EARLY_BIT 0
`define EBU_GAP_BIT 1
`define EBU_BCFG_RESET 16'h0001
// ==========================================================
// Sequencer states
`define EBU_S_IDLE 4'h0
`define EBU_S_GAP 4'h1
`define EBU_S_T1 4'h2
`define EBU_S_TW 4'h3
`define EBU_S_T2 4'h4
`define EBU_S_TB 4'h5
`define EBU_S_T2B 4'h6
`define EBU_S_T3 4'h7
`define EBU_S_HOLD 4'h8
`define EBU_S_T12 4'h9
`endif

// File: tb/ebu_properties.sv
// Port-level assertions for the external bus unit.
`timescale 1ns/1ps
module ebu_props #(parameter ADDR_W = 20) (
	input logic CLK,
	input logic SYS_RST,
	input logic CE,
	input logic REG_WR,
	input logic REG_RD,
	input logic [3:0] REG_ADDR,
	input logic [15:0] REG_WDATA,
	input logic [15:0] REG_RDATA,
	input logic [15:0] CORE_WDATA,
	input logic [15:0] CORE_RDATA,
	input logic CORE_REQ,
	input logic CORE_WRITE,
	input logic CORE_WORD,
	input logic CORE_BUSY,
	input logic CORE_DONE,
	input logic [ADDR_W-1:0] CORE_ADDR,
	input logic [ADDR_W-1:0] EXT_ADDR,
	input logic [15:0] EXT_DATA_IN,
	input logic [15:0] EXT_DATA_OUT,
	input logic [1:0] EXT_DATA_OE,
	input logic [3:0] ZONE_SELECT_N,
	input logic BASE_MEMORY_SELECT_N,
	input logic READ_STROBE_N,
	input logic EVEN_BYTE_WRITE_STROBE_N,
	input logic ODD_BYTE_WRITE_STROBE_N
);
	// ==========
	// Width of each zone and the transfer in flight, seen from the ports.
	logic [3:0] wide;
	logic [1:0] zone;
	logic word;
	wire sel = ~&ZONE_SELECT_N;
	wire take = CE && CORE_REQ && !CORE_BUSY;
	wire [1:0] wr_n = {ODD_BYTE_WRITE_STROBE_N, EVEN_BYTE_WRITE_STROBE_N};
	always @(posedge CLK) begin
		if (SYS_RST) begin
			wide <= 4'h0;
			zone <= 2'h0;
			word <= 1'h0;
		end else if (CE) begin
			if (REG_WR && !REG_ADDR[3:2])
				wide[REG_ADDR[1:0]] <= REG_WDATA[6];
			if (take) begin
				zone <= CORE_ADDR[ADDR_W-1 -: 2];
				word <= CORE_WORD;
			end
		end
	end
	// ==========
	// Properties.
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	property p_one; $onehot0(~ZONE_SELECT_N); endproperty
	a_one: assert property (p_one) else $error("two selects");
	property p_zone; sel |-> !ZONE_SELECT_N[zone]; endproperty
	a_zone: assert property (p_zone) else $error("wrong zone");
	property p_base; BASE_MEMORY_SELECT_N == &ZONE_SELECT_N[2:1]; endproperty
	a_base: assert property (p_base) else $error("base select");
	property p_oe; sel |-> (EXT_DATA_OE | wr_n) == 2'h3; endproperty
	a_oe: assert property (p_oe) else $error("strobe lane");
	property p_narrow;
		CORE_BUSY && !wide[zone] |-> wr_n[1] && !EXT_DATA_OE[1];
	endproperty
	a_narrow: assert property (p_narrow) else $error("high lane");
	property p_float; CORE_BUSY && !word |-> EXT_DATA_OE != 2'h3; endproperty
	a_float: assert property (p_float) else $error("both lanes");
	property p_done; CORE_DONE |-> !CORE_BUSY ##1 !CORE_DONE; endproperty
	a_done: assert property (p_done) else $error("done pulse");
	property p_idle;
		!CORE_BUSY |-> !sel && READ_STROBE_N && wr_n == 2'h3 && !EXT_DATA_OE;
	endproperty
	a_idle: assert property (p_idle) else $error("bus not idle");
	c_base: cover property (!BASE_MEMORY_SELECT_N);
	c_word: cover property (take && CORE_WORD && CORE_WRITE);
	c_rd: cover property (take && !CORE_WRITE);
endmodule // ebu_props
bind ebu_top ebu_props #(.ADDR_W(ADDR_W)) u_props (.*);

// File: tb/ebu_mem_model.sv
// Behavioural static memory on the far side of the bus unit.
`timescale 1ns/1ps
module ebu_mem_model (
	input logic CLK,
	input logic [19:0] a,
	input logic [3:0] sel_n,
	input logic rd_n,
	input logic w0_n,
	input logic w1_n,
	input logic [15:0] dq_o,
	input logic [1:0] oe,
	input logic [3:0] wide,
	output logic [15:0] dq_i
);
	logic [7:0] mem [0:63];
	logic [15:0] junk = 16'h5aa5;
	wire on = ~&sel_n;
	wire w = wide[a[19:18]];
	wire [5:0] i = {a[19:18], a[3:0]};
	wire [5:0] e = {i[5:1], 1'b0};
	// Undriven lines toggle, so a stale sample can never pass as data.
	always @(posedge CLK) begin
		junk <= ~junk;
		if (on && !w0_n && oe[0])
			mem[w ? e : i] <= dq_o[7:0];
		if (on && w && !w1_n && oe[1])
			mem[e + 6'h1] <= dq_o[15:8];
	end
	always @* begin
		dq_i = junk;
		if (on && !rd_n)
			dq_i = w ? {mem[e + 6'h1], mem[e]} : {junk[15:8], mem[i]};
	end
endmodule // ebu_mem_model

// File: tb/testbench.sv
// Self-checking bench for the external bus unit.
`timescale 1ns/1ps
module testbench;
	logic CLK = 1'b0, SYS_RST = 1'b1, CE = 1'b1, REG_WR = 1'b0;
	logic REG_RD = 1'b0, CORE_REQ = 1'b0, CORE_WRITE = 1'b0;
	logic CORE_WORD = 1'b0, wd;
	logic [3:0] REG_ADDR = 4'h0, z;
	logic [15:0] REG_WDATA = 16'h0, CORE_WDATA = 16'h0, lat, b;
	logic [19:0] CORE_ADDR = 20'h0, ad;
	wire [15:0] REG_RDATA, CORE_RDATA, EXT_DATA_OUT, EXT_DATA_IN;
	wire [19:0] EXT_ADDR;
	wire [1:0] EXT_DATA_OE;
	wire [3:0] ZONE_SELECT_N;
	wire CORE_BUSY, CORE_DONE, BASE_MEMORY_SELECT_N, READ_STROBE_N;
	wire EVEN_BYTE_WRITE_STROBE_N, ODD_BYTE_WRITE_STROBE_N;
	int num_errors = 0, checks = 0, cyc = 0;
	always #25 CLK = ~CLK;
	ebu_top dut (.*);
	ebu_mem_model mem (.CLK(CLK), .a(EXT_ADDR), .sel_n(ZONE_SELECT_N),
		.rd_n(READ_STROBE_N), .w0_n(EVEN_BYTE_WRITE_STROBE_N),
		.w1_n(ODD_BYTE_WRITE_STROBE_N), .dq_o(EXT_DATA_OUT),
		.oe(EXT_DATA_OE), .wide(4'h6), .dq_i(EXT_DATA_IN));
	// ==========
	// Shared bus tasks.
	task chk(input string s, input logic [15:0] x, y);
		checks++;
		if (y !== x) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", s, x, y);
		end
	endtask
	task rw(input logic [3:0] a, input logic [15:0] d);
		@(posedge CLK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
		@(posedge CLK) REG_WR <= 1'b0;
	endtask
	task rr(input logic [3:0] a, input logic [15:0] x);
		@(posedge CLK) {REG_RD, REG_ADDR} <= {1'b1, a};
		@(posedge CLK) REG_RD <= 1'b0;
		#1 chk("reg", x, REG_RDATA);
	endtask
	// A nonzero m swaps in address a2 in the cycle the first transfer ends.
	task xf(input logic w, ww, input logic [19:0] a, a2,
		input logic [15:0] d, input int m);
		@(posedge CLK) {CORE_REQ, CORE_WRITE, CORE_WORD} <= {1'b1, w, ww};
		CORE_ADDR <= a;
		CORE_WDATA <= d;
		@(posedge CLK);
		if (m > 0) begin
			repeat (m) @(posedge CLK);
			CORE_ADDR <= a2;
			@(posedge CLK);
		end
		CORE_REQ <= 1'b0;
		lat = 16'h0;
		do begin
			@(posedge CLK);
			#1 lat++;
		end while (CORE_DONE !== 1'b1 && lat < 16'h63);
		chk("done", 16'h0001, {15'h0, CORE_DONE});
	endtask
	task lt(input logic [15:0] cfg, input logic w, input logic [15:0] x);
		rw(z, cfg);
		xf(w, wd, ad, ad, 16'h0, 0);
		chk("cycles", x, lat);
	endtask
	// ==========
	// Scenarios.
	task t_regs;
		for (logic [3:0] i = 4'h0; i < 4'h4; i++)
			rr(i, 16'h0007);
		rr(4'h4, 16'h0001);
		rr(4'hf, 16'h0);
		rw(4'h0, 16'hffff);
		rr(4'h0, 16'h03ff);
	endtask
	task t_time;
		z = 4'h1;
		ad = 20'h40000;
		wd = 1'b0;
		rw(z, 16'h0040);
		xf(1'b0, 1'b0, ad, ad, 16'h0, 0);
		b = lat;
		chk("basic", 16'h0002, b);
		lt(16'h0047, 1'b0, b + 16'h7);
		lt(16'h0058, 1'b0, b + 16'h3);
		lt(16'h00c0, 1'b0, b - 16'h1);
		lt(16'h0040, 1'b1, b + 16'h1);
		rw(4'h4, 16'h0);
		lt(16'h0040, 1'b1, b);
	endtask
	task t_gap;
		rw(4'h2, 16'h0040);
		rw(4'h4, 16'h0002);
		xf(1'b0, 1'b0, 20'h40000, 20'h80000, 16'h0, b);
		chk("gap", b + 16'h1, lat);
		xf(1'b0, 1'b0, 20'h40000, 20'h40002, 16'h0, b);
		chk("no gap", b, lat);
	endtask
	task t_wide;
		xf(1'b1, 1'b1, 20'h40000, 20'h0, 16'ha55a, 0);
		xf(1'b1, 1'b0, 20'h40003, 20'h0, 16'h3c00, 0);
		xf(1'b1, 1'b0, 20'h40002, 20'h0, 16'h00c3, 0);
		xf(1'b0, 1'b1, 20'h40002, 20'h0, 16'h0, 0);
		chk("word", 16'h3cc3, CORE_RDATA);
		xf(1'b0, 1'b0, 20'h40001, 20'h0, 16'h0, 0);
		chk("odd", 16'h00a5, {8'h0, CORE_RDATA[15:8]});
	endtask
	task t_narrow;
		rw(4'h0, 16'h0);
		xf(1'b1, 1'b1, 20'h00004, 20'h0, 16'h1234, 0);
		xf(1'b0, 1'b0, 20'h00005, 20'h0, 16'h0, 0);
		chk("odd", 16'h0012, {8'h0, CORE_RDATA[15:8]});
		xf(1'b0, 1'b0, 20'h00004, 20'h0, 16'h0, 0);
		b = lat;
		chk("even", 16'h0034, {8'h0, CORE_RDATA[7:0]});
		xf(1'b0, 1'b1, 20'h00004, 20'h0, 16'h0, 0);
		chk("word", 16'h1234, CORE_RDATA);
	endtask
	task t_burst;
		z = 4'h3;
		ad = 20'hc0000;
		wd = 1'b1;
		rw(z, 16'h0);
		xf(1'b1, 1'b1, ad, ad, 16'hbeef, 0);
		lt(16'h0020, 1'b0, b + 16'h1);
		chk("burst", 16'hbeef, CORE_RDATA);
		lt(16'h0220, 1'b0, b + 16'h3);
		lt(16'h0320, 1'b0, b + 16'h3);
	endtask
	// ==========
	// Run control.
	task complete_run;
		if (num_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			complete_run;
		end
	end
	initial begin
		repeat (8) @(posedge CLK);
		SYS_RST <= 1'b0;
		t_regs;
		t_time;
		t_gap;
		t_wide;
		t_narrow;
		t_burst;
		complete_run;
	end
endmodule // testbench
